/* src/clksw_pkg.sv */
package clksw_pkg;

	// register byte addresses
	localparam logic [7:0] OFS_OPMODE = 8'h00;
	localparam logic [7:0] OFS_MOSC   = 8'h04;
	localparam logic [7:0] OFS_MAINMODE = 8'h08;
	localparam logic [7:0] OFS_IOSC   = 8'h0c;
	localparam logic [7:0] OFS_PCLK   = 8'h10;
	localparam logic [7:0] OFS_STAB   = 8'h14;

	// field positions
	localparam int BIT_EXT       = 7;
	localparam int BIT_MAINPIN   = 6;
	localparam int BIT_SUBPIN    = 4;
	localparam int BIT_MAIN_HALT = 7;
	localparam int BIT_PERIPH_SEL = 2;
	localparam int BIT_MAIN_STAT = 1;
	localparam int BIT_CPU_MAIN  = 0;
	localparam int BIT_RUNNING   = 7;
	localparam int BIT_LS_HALT   = 1;
	localparam int BIT_HS_HALT   = 0;
	localparam int BIT_CPU_SUB   = 4;
	localparam int BIT_SUB_STAT  = 5;

	// values after reset
	localparam logic RST_MAIN_HALT = 1'b1;
	localparam logic RST_OTHER     = 1'b0;

	// timing
	localparam int CLK_MHZ           = 20;
	localparam int RESET_PROC_US_MIN = 11;
	localparam int RESET_PROC_US_MAX = 47;
	localparam int RESET_PROC_CYC    = RESET_PROC_US_MIN * CLK_MHZ;
	localparam int PROC_W            = $clog2(RESET_PROC_CYC + 1);
	localparam int HS_START_CYC      = 16;
	localparam logic [7:0] STAB_MAX  = 8'hff;

	typedef enum logic [2:0] {st_pre, st_proc, st_run, st_halt, st_stop} cpu_state_e;
	typedef enum logic [1:0] {src_hs, src_main, src_sub} clk_src_e;

endpackage

/* src/clk_src_gate.sv */
`timescale 1ns/1ns
`default_nettype none

// one leg of the cpu clock multiplexer; a leg opens or closes only on its own source tick
module clk_src_gate (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic tick,
	input  wire logic req,
	input  wire logic others_on,
	output logic      on,
	output logic      gated_tick
);

	typedef struct packed {
		logic on;
	} state_s;

	state_s s_q;
	state_s s_d;

	always_comb begin
		s_d = s_q;
		// close on own edge when deselected; open on own edge once every other leg is closed
		if (tick) begin
			if (s_q.on && !req)
				s_d.on = 1'b0; // R22
			else if (!s_q.on && req && !others_on)
				s_d.on = 1'b1; // R22
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign on         = s_q.on;
	assign gated_tick = tick & s_q.on;

	a_leg_opens_alone: assert property (@(posedge clk) disable iff (!reset_n) // R22
		$rose(s_q.on) |-> $past(!others_on && req && tick))
		else $error("leg opened while another leg was open");

	a_leg_closes_own: assert property (@(posedge clk) disable iff (!reset_n) // R22
		$fell(s_q.on) |-> $past(tick && !req))
		else $error("leg closed off its own edge");

endmodule // clk_src_gate

`default_nettype wire

/* src/cpu_clock_source_switcher.sv */
// Overview of operation
// R1: clearing the low-speed halt bit restarts the low-speed oscillator.
// R2: after reset the cpu runs from the internal high-speed oscillator.
// R3: in high poc mode wait for supply, then a reset processing delay.
// R4: software enables the resonator, checks stabilization, then sets both main selects.
// R5: for external main clock input software skips the stabilization check.
// R6: the peripheral main select can change only once after reset.
// R7: software starts the subsystem oscillator, waits, then selects it for the cpu.
// R8: software restarts the internal oscillator, polls running, then clears main select.
// R9: from main clock, software starts the subsystem oscillator, waits, selects it.
// R10: oscillator start may be skipped when the subsystem clock already runs.
// R11: to internal from subsystem, software restarts, confirms, clears selects.
// R12: to main from subsystem, software enables main, sets selects, clears subsystem.
// R13: halt from each source enters a distinct halt state tied to that source.
// R14: software stops unsupported peripherals before the stop instruction.
// R15: mode register: external input bit 7, main pin bit 6, subsystem bit 4.
// R16: internal oscillator register: running status bit 7, halt bit 0.
// R17: main select bits 2 and 0, main halt bit 7, subsystem select bit 4.
// R18: setting low-speed halt stops that oscillator unless the option forbids it.
// R19: setting the internal high-speed halt stops it; cpu must use another source.
// R20: clearing subsystem pin mode stops it; cpu must not use it.
// R21: cpu status reads internal, main or subsystem from two status bits.
// R22: the cpu clock mux switches glitch free on edges of both clocks.
// R23: halting the oscillator that drives the cpu is ignored.
`timescale 1ns/1ns
`default_nettype none

module cpu_clock_source_switcher #(
	parameter int HS_START = clksw_pkg::HS_START_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        poweron_clear_level_sel,
	input  wire logic        supply_above_threshold,
	input  wire logic        lowspeed_stop_allowed,
	input  wire logic        hs_tick,
	input  wire logic        main_tick,
	input  wire logic        sub_tick,
	input  wire logic        halt_exec,
	input  wire logic        stop_exec,
	input  wire logic        wake_event,
	output logic             cpu_clk_en,
	output logic             cpu_running,
	output logic             cpu_halted,
	output logic             cpu_stopped,
	output logic      [1:0]  halt_source,
	output logic             hs_osc_enable,
	output logic             main_osc_enable,
	output logic             ext_clock_input_enable,
	output logic             sub_osc_enable,
	output logic             lowspeed_osc_enable,
	output logic             periph_main_clk_sel
);

	localparam int HS_W = $clog2(HS_START + 1);

	typedef struct packed {
		clksw_pkg::cpu_state_e      st;
		clksw_pkg::clk_src_e        halt_src;
		logic [clksw_pkg::PROC_W-1:0] proc_cnt;
		logic                       ext_clock_input_sel;
		logic                       main_pin_osc_mode;
		logic                       sub_pin_osc_mode;
		logic                       main_osc_halt;
		logic                       peripheral_main_clock_sel;
		logic                       periph_sel_locked;
		logic                       cpu_main_clock_sel;
		logic                       cpu_sub_clock_sel;
		logic                       hs_internal_osc_halt;
		logic                       lowspeed_osc_halt;
		logic [HS_W-1:0]            hs_cnt;
		logic                       hs_internal_osc_running;
		logic [7:0]                 osc_stab_counter_status;
		logic                       ack;
		logic [31:0]                rdata;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic                  in_stop;
	logic                  hs_t;
	logic                  main_t;
	logic                  sub_t;
	logic                  on_hs;
	logic                  on_main;
	logic                  on_sub;
	logic                  g_hs;
	logic                  g_main;
	logic                  g_sub;
	logic                  cpu_on_main_status;
	logic                  cpu_on_sub_status;
	clksw_pkg::clk_src_e   req_src;
	clksw_pkg::clk_src_e   cur_src;
	logic                  bus_req;
	logic                  wr_ok;
	logic [7:0]            wd;
	logic [7:0]            rd_mux;

	// the stop instruction halts both high-speed sources; the subsystem oscillator keeps going
	assign in_stop                = (s_q.st == clksw_pkg::st_stop);
	assign hs_osc_enable          = !s_q.hs_internal_osc_halt && !in_stop; // R19
	assign main_osc_enable        = s_q.main_pin_osc_mode && !s_q.ext_clock_input_sel
	                                && !s_q.main_osc_halt && !in_stop;
	assign ext_clock_input_enable = s_q.main_pin_osc_mode && s_q.ext_clock_input_sel
	                                && !s_q.main_osc_halt && !in_stop;
	assign sub_osc_enable         = s_q.sub_pin_osc_mode; // R20
	assign lowspeed_osc_enable    = !(s_q.lowspeed_osc_halt && lowspeed_stop_allowed); // R1 R18
	assign periph_main_clk_sel    = s_q.peripheral_main_clock_sel;

	assign hs_t   = hs_tick && hs_osc_enable;
	assign main_t = main_tick && (main_osc_enable || ext_clock_input_enable);
	assign sub_t  = sub_tick && sub_osc_enable;

	// subsystem select wins over the main select
	assign req_src = s_q.cpu_sub_clock_sel  ? clksw_pkg::src_sub :
	                 s_q.cpu_main_clock_sel ? clksw_pkg::src_main : clksw_pkg::src_hs;

	clk_src_gate u_leg_hs (
		.clk        (clk),
		.reset_n    (reset_n),
		.tick       (hs_t),
		.req        (req_src == clksw_pkg::src_hs),
		.others_on  (on_main || on_sub),
		.on         (on_hs),
		.gated_tick (g_hs)
	);

	clk_src_gate u_leg_main (
		.clk        (clk),
		.reset_n    (reset_n),
		.tick       (main_t),
		.req        (req_src == clksw_pkg::src_main),
		.others_on  (on_hs || on_sub),
		.on         (on_main),
		.gated_tick (g_main)
	);

	clk_src_gate u_leg_sub (
		.clk        (clk),
		.reset_n    (reset_n),
		.tick       (sub_t),
		.req        (req_src == clksw_pkg::src_sub),
		.others_on  (on_hs || on_main),
		.on         (on_sub),
		.gated_tick (g_sub)
	);

	// status follows the open leg, not the select bits
	assign cpu_on_sub_status  = on_sub; // R21 R22
	assign cpu_on_main_status = on_main;
	assign cur_src = cpu_on_sub_status  ? clksw_pkg::src_sub :
	                 cpu_on_main_status ? clksw_pkg::src_main : clksw_pkg::src_hs; // R21

	assign cpu_running = (s_q.st == clksw_pkg::st_run);
	assign cpu_halted  = (s_q.st == clksw_pkg::st_halt);
	assign cpu_stopped = in_stop;
	assign halt_source = s_q.halt_src;
	assign cpu_clk_en  = cpu_running && (g_hs || g_main || g_sub);

	assign bus_req     = read || write;
	assign waitrequest = bus_req && !s_q.ack;
	assign readdata    = s_q.rdata;
	assign wd          = writedata[7:0];
	assign wr_ok       = write && s_q.ack && byteenable[0];

	always_comb begin
		rd_mux = 8'h00;
		case (address)
			clksw_pkg::OFS_OPMODE: begin
				rd_mux[clksw_pkg::BIT_EXT]     = s_q.ext_clock_input_sel; // R15
				rd_mux[clksw_pkg::BIT_MAINPIN] = s_q.main_pin_osc_mode;
				rd_mux[clksw_pkg::BIT_SUBPIN]  = s_q.sub_pin_osc_mode;
			end
			clksw_pkg::OFS_MOSC: rd_mux[clksw_pkg::BIT_MAIN_HALT] = s_q.main_osc_halt; // R17
			clksw_pkg::OFS_MAINMODE: begin
				rd_mux[clksw_pkg::BIT_PERIPH_SEL] = s_q.peripheral_main_clock_sel; // R17
				rd_mux[clksw_pkg::BIT_MAIN_STAT]  = cpu_on_main_status;
				rd_mux[clksw_pkg::BIT_CPU_MAIN]   = s_q.cpu_main_clock_sel;
			end
			clksw_pkg::OFS_IOSC: begin
				rd_mux[clksw_pkg::BIT_RUNNING] = s_q.hs_internal_osc_running; // R16
				rd_mux[clksw_pkg::BIT_LS_HALT] = s_q.lowspeed_osc_halt;
				rd_mux[clksw_pkg::BIT_HS_HALT] = s_q.hs_internal_osc_halt;
			end
			clksw_pkg::OFS_PCLK: begin
				rd_mux[clksw_pkg::BIT_CPU_SUB]  = s_q.cpu_sub_clock_sel; // R17
				rd_mux[clksw_pkg::BIT_SUB_STAT] = cpu_on_sub_status;
			end
			clksw_pkg::OFS_STAB: rd_mux = s_q.osc_stab_counter_status;
			default: rd_mux = 8'h00;
		endcase
	end

	always_comb begin
		s_d = s_q;
		// one wait state per access; read data is sampled in the wait cycle
		s_d.ack = bus_req && !s_q.ack;
		if (bus_req && !s_q.ack)
			s_d.rdata = read ? {24'h000000, rd_mux} : 32'h00000000;

		if (wr_ok) begin
			case (address)
				clksw_pkg::OFS_OPMODE: begin
					s_d.ext_clock_input_sel = wd[clksw_pkg::BIT_EXT];
					s_d.main_pin_osc_mode   = wd[clksw_pkg::BIT_MAINPIN];
					// the subsystem oscillator cannot be dropped under a cpu that uses or wants it
					if (wd[clksw_pkg::BIT_SUBPIN] || (cur_src != clksw_pkg::src_sub
					    && req_src != clksw_pkg::src_sub))
						s_d.sub_pin_osc_mode = wd[clksw_pkg::BIT_SUBPIN]; // R20 R23
				end
				clksw_pkg::OFS_MOSC: begin
					if (!wd[clksw_pkg::BIT_MAIN_HALT] || (cur_src != clksw_pkg::src_main
					    && req_src != clksw_pkg::src_main))
						s_d.main_osc_halt = wd[clksw_pkg::BIT_MAIN_HALT]; // R23
				end
				clksw_pkg::OFS_MAINMODE: begin
					if (!s_q.periph_sel_locked
					    && wd[clksw_pkg::BIT_PERIPH_SEL] != s_q.peripheral_main_clock_sel) begin
						s_d.peripheral_main_clock_sel = wd[clksw_pkg::BIT_PERIPH_SEL]; // R6
						s_d.periph_sel_locked         = 1'b1; // R6
					end
					s_d.cpu_main_clock_sel = wd[clksw_pkg::BIT_CPU_MAIN];
				end
				clksw_pkg::OFS_IOSC: begin
					s_d.lowspeed_osc_halt = wd[clksw_pkg::BIT_LS_HALT]; // R1 R18
					if (!wd[clksw_pkg::BIT_HS_HALT] || (cur_src != clksw_pkg::src_hs
					    && req_src != clksw_pkg::src_hs))
						s_d.hs_internal_osc_halt = wd[clksw_pkg::BIT_HS_HALT]; // R19 R23
				end
				clksw_pkg::OFS_PCLK: s_d.cpu_sub_clock_sel = wd[clksw_pkg::BIT_CPU_SUB];
				default: ;
			endcase
		end

		// running status only after the start-up count with the oscillator enabled
		if (!hs_osc_enable) begin
			s_d.hs_cnt                  = '0;
			s_d.hs_internal_osc_running = 1'b0;
		end else if (s_q.hs_cnt != HS_W'(HS_START))
			s_d.hs_cnt = s_q.hs_cnt + HS_W'(1);
		else
			s_d.hs_internal_osc_running = 1'b1; // R16

		// stabilization count of the resonator; stays at zero for external input
		if (!main_osc_enable)
			s_d.osc_stab_counter_status = 8'h00;
		else if (main_t && s_q.osc_stab_counter_status != clksw_pkg::STAB_MAX)
			s_d.osc_stab_counter_status = s_q.osc_stab_counter_status + 8'h01;

		case (s_q.st)
			clksw_pkg::st_pre: begin
				// low poc mode has no supply gate here; only the higher level waits
				if (!poweron_clear_level_sel || supply_above_threshold)
					s_d.st = clksw_pkg::st_proc; // R3
			end
			clksw_pkg::st_proc: begin
				if (s_q.proc_cnt == clksw_pkg::PROC_W'(clksw_pkg::RESET_PROC_CYC - 1))
					s_d.st = clksw_pkg::st_run; // R2 R3
				else
					s_d.proc_cnt = s_q.proc_cnt + clksw_pkg::PROC_W'(1); // R3
			end
			clksw_pkg::st_run: begin
				if (halt_exec) begin
					s_d.st       = clksw_pkg::st_halt; // R13
					s_d.halt_src = cur_src; // R13
				end else if (stop_exec && cur_src != clksw_pkg::src_sub)
					s_d.st = clksw_pkg::st_stop;
			end
			clksw_pkg::st_halt, clksw_pkg::st_stop: begin
				if (wake_event)
					s_d.st = clksw_pkg::st_run;
			end
			default: s_d.st = clksw_pkg::st_pre;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s_q                      <= '0;
			s_q.st                   <= clksw_pkg::st_pre;
			s_q.halt_src             <= clksw_pkg::src_hs;
			s_q.main_osc_halt        <= clksw_pkg::RST_MAIN_HALT;
			s_q.cpu_main_clock_sel   <= clksw_pkg::RST_OTHER; // R2
			s_q.cpu_sub_clock_sel    <= clksw_pkg::RST_OTHER; // R2
			s_q.hs_internal_osc_halt <= clksw_pkg::RST_OTHER; // R2
		end else
			s_q <= s_d;
	end

	a_periph_single_change: assert property (@(posedge clk) disable iff (!reset_n) // R6
		s_q.periph_sel_locked |=> $stable(s_q.peripheral_main_clock_sel))
		else $error("peripheral main select changed twice");

	a_proc_delay_exact: assert property (@(posedge clk) disable iff (!reset_n) // R3
		$rose(cpu_running) && !$past(cpu_halted || cpu_stopped) |-> $past(s_q.st == clksw_pkg::st_proc)
		&& $past(s_q.proc_cnt) == clksw_pkg::PROC_W'(clksw_pkg::RESET_PROC_CYC - 1))
		else $error("run entered without full reset processing delay");

	a_pre_holds_low: assert property (@(posedge clk) disable iff (!reset_n) // R3
		s_q.st == clksw_pkg::st_pre && poweron_clear_level_sel && !supply_above_threshold
		|=> s_q.st == clksw_pkg::st_pre)
		else $error("left pre-reset before supply detection");

	a_default_hs_select: assert property (@(posedge clk) disable iff (!reset_n) // R2
		s_q.st == clksw_pkg::st_proc |-> !s_q.cpu_sub_clock_sel && !s_q.cpu_main_clock_sel
		&& hs_osc_enable)
		else $error("internal high-speed source not default after reset");

	a_lowspeed_control: assert property (@(posedge clk) disable iff (!reset_n) // R1 R18
		wr_ok && address == clksw_pkg::OFS_IOSC
		|=> lowspeed_osc_enable == !($past(wd[clksw_pkg::BIT_LS_HALT]) && $past(lowspeed_stop_allowed)))
		else $error("low-speed oscillator did not follow halt bit");

	a_halt_tied_source: assert property (@(posedge clk) disable iff (!reset_n) // R13
		cpu_running && halt_exec |=> cpu_halted && halt_source == $past(cur_src))
		else $error("halt state not tied to running source");

	a_cpu_source_kept: assert property (@(posedge clk) disable iff (!reset_n) // R23
		!in_stop && cur_src == clksw_pkg::src_hs && !(on_main || on_sub) |-> hs_osc_enable)
		else $error("internal oscillator halted under the cpu");

	a_sub_kept_running: assert property (@(posedge clk) disable iff (!reset_n) // R20 R23
		cpu_on_sub_status |-> sub_osc_enable)
		else $error("subsystem oscillator stopped under the cpu");

	a_one_leg_open: assert property (@(posedge clk) disable iff (!reset_n) // R21 R22
		$onehot0({on_hs, on_main, on_sub}))
		else $error("more than one clock leg open");

	a_field_positions: assert property (@(posedge clk) disable iff (!reset_n) // R16
		read && !s_q.ack && address == clksw_pkg::OFS_IOSC
		|=> readdata[clksw_pkg::BIT_HS_HALT] == $past(s_q.hs_internal_osc_halt))
		else $error("internal oscillator register field misplaced");

endmodule // cpu_clock_source_switcher

`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	localparam int TIMEOUT = 20000;
	localparam logic [7:0] RA [6] = '{clksw_pkg::OFS_OPMODE, clksw_pkg::OFS_MOSC, clksw_pkg::OFS_MAINMODE,
		clksw_pkg::OFS_IOSC, clksw_pkg::OFS_PCLK, clksw_pkg::OFS_STAB};
	localparam logic [7:0] RV [6] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};

	logic        clk;
	logic        reset_n;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        poweron_clear_level_sel;
	logic        supply_above_threshold;
	logic        lowspeed_stop_allowed;
	logic        hs_tick;
	logic        main_tick;
	logic        sub_tick;
	logic        halt_exec;
	logic        stop_exec;
	logic        wake_event;
	logic        cpu_clk_en;
	logic        cpu_running;
	logic        cpu_halted;
	logic        cpu_stopped;
	logic [1:0]  halt_source;
	logic        hs_osc_enable;
	logic        main_osc_enable;
	logic        ext_clock_input_enable;
	logic        sub_osc_enable;
	logic        lowspeed_osc_enable;
	logic        periph_main_clk_sel;
	int          failures = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          n;
	logic [31:0] rd;

	// short start-up count keeps the run brief
	cpu_clock_source_switcher #(.HS_START(2)) uut (.clk(clk), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .poweron_clear_level_sel(poweron_clear_level_sel),
		.supply_above_threshold(supply_above_threshold), .lowspeed_stop_allowed(lowspeed_stop_allowed),
		.hs_tick(hs_tick), .main_tick(main_tick), .sub_tick(sub_tick), .halt_exec(halt_exec),
		.stop_exec(stop_exec), .wake_event(wake_event), .cpu_clk_en(cpu_clk_en), .cpu_running(cpu_running),
		.cpu_halted(cpu_halted), .cpu_stopped(cpu_stopped), .halt_source(halt_source),
		.hs_osc_enable(hs_osc_enable), .main_osc_enable(main_osc_enable),
		.ext_clock_input_enable(ext_clock_input_enable), .sub_osc_enable(sub_osc_enable),
		.lowspeed_osc_enable(lowspeed_osc_enable), .periph_main_clk_sel(periph_main_clk_sel));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// unrelated tick rates so leg switching sees uneven edges
	always @(posedge clk) begin
		cyc <= cyc + 1;
		hs_tick <= (cyc % 2 == 0);
		main_tick <= (cyc % 3 == 0);
		sub_tick <= (cyc % 5 == 0);
		if (cyc == TIMEOUT) begin
			failures++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// waitrequest and readdata are taken at the rising edge; the falling edge at the end lets callers see settled outputs
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
		int k;
		k = 0;
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, d};
		byteenable <= be;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50)
			check("bus answer", 32'h0, {31'h0, waitrequest});
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hf);
		check(what, {24'h0, e}, rd & {24'h0, m});
	endtask

	task automatic poll(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		int k;
		k = 0;
		do begin
			bus(1'b0, a, 8'h00, 4'hf);
			k++;
		end while ((rd & {24'h0, m}) !== {24'h0, e} && k < 400);
		check(what, {24'h0, e}, rd & {24'h0, m});
	endtask

	task automatic pulse(input int which);
		@(posedge clk);
		halt_exec <= (which == 0);
		stop_exec <= (which == 1);
		wake_event <= (which == 2);
		@(posedge clk);
		halt_exec <= 1'b0;
		stop_exec <= 1'b0;
		wake_event <= 1'b0;
		@(negedge clk);
	endtask

	initial begin
		reset_n = 1'b0;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'hf;
		poweron_clear_level_sel = 1'b1;
		supply_above_threshold = 1'b0;
		lowspeed_stop_allowed = 1'b0;
		hs_tick = 1'b0;
		main_tick = 1'b0;
		sub_tick = 1'b0;
		halt_exec = 1'b0;
		stop_exec = 1'b0;
		wake_event = 1'b0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (40) @(posedge clk);
		@(negedge clk);
		check("running before supply", 32'h0, {31'h0, cpu_running});
		@(posedge clk);
		supply_above_threshold <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cpu_running !== 1'b1 && n < 400);
		check("reset delay", 32'h1, {31'h0, n >= clksw_pkg::RESET_PROC_CYC && n <= clksw_pkg::RESET_PROC_CYC + 3});
		for (int i = 0; i < 6; i++)
			rdchk("reset value", RA[i], 8'hff, RV[i]);
		check("outputs after reset", 32'h24, {26'h0, hs_osc_enable, main_osc_enable, sub_osc_enable,
			lowspeed_osc_enable, periph_main_clk_sel, cpu_halted});
		rdchk("unmapped read", 8'h18, 8'hff, 8'h00);
		wr(8'h18, 8'hff);
		wr(clksw_pkg::OFS_OPMODE, 8'h40);
		wr(clksw_pkg::OFS_MOSC, 8'h00);
		check("resonator on", 32'h1, {31'h0, main_osc_enable});
		poll("stabilization count", clksw_pkg::OFS_STAB, 8'hff, 8'hff);
		wr(clksw_pkg::OFS_MAINMODE, 8'h05);
		poll("cpu on main", clksw_pkg::OFS_MAINMODE, 8'h07, 8'h07);
		check("periph select", 32'h1, {31'h0, periph_main_clk_sel});
		wr(clksw_pkg::OFS_MOSC, 8'h80);
		rdchk("busy main halt", clksw_pkg::OFS_MOSC, 8'h80, 8'h00);
		wr(clksw_pkg::OFS_IOSC, 8'h01);
		check("hs stopped", 32'h0, {31'h0, hs_osc_enable});
		poll("hs not running", clksw_pkg::OFS_IOSC, 8'h81, 8'h01);
		wr(clksw_pkg::OFS_MAINMODE, 8'h01);
		rdchk("periph lock", clksw_pkg::OFS_MAINMODE, 8'h04, 8'h04);
		pulse(0);
		check("halt on main", 32'h5, {29'h0, cpu_halted, halt_source});
		pulse(2);
		check("wake", 32'h1, {31'h0, cpu_running});
		wr(clksw_pkg::OFS_IOSC, 8'h00);
		poll("hs running", clksw_pkg::OFS_IOSC, 8'h81, 8'h80);
		wr(clksw_pkg::OFS_MAINMODE, 8'h04);
		poll("cpu on internal", clksw_pkg::OFS_MAINMODE, 8'h03, 8'h00);
		wr(clksw_pkg::OFS_IOSC, 8'h01);
		rdchk("busy hs halt", clksw_pkg::OFS_IOSC, 8'h01, 8'h00);
		pulse(0);
		check("halt on internal", 32'h4, {29'h0, cpu_halted, halt_source});
		pulse(2);
		wr(clksw_pkg::OFS_OPMODE, 8'h50);
		check("sub osc on", 32'h1, {31'h0, sub_osc_enable});
		wr(clksw_pkg::OFS_PCLK, 8'h10);
		poll("cpu on sub", clksw_pkg::OFS_PCLK, 8'h30, 8'h30);
		pulse(0);
		check("halt on sub", 32'h6, {29'h0, cpu_halted, halt_source});
		pulse(2);
		pulse(1);
		check("stop on sub ignored", 32'h0, {31'h0, cpu_stopped});
		wr(clksw_pkg::OFS_PCLK, 8'h00);
		poll("back to internal", clksw_pkg::OFS_PCLK, 8'h30, 8'h00);
		wr(clksw_pkg::OFS_OPMODE, 8'h40);
		check("sub osc off", 32'h0, {31'h0, sub_osc_enable});
		wr(clksw_pkg::OFS_OPMODE, 8'hc0);
		check("external input", 32'h2, {30'h0, ext_clock_input_enable, main_osc_enable});
		bus(1'b1, clksw_pkg::OFS_OPMODE, 8'h00, 4'h0);
		rdchk("masked write", clksw_pkg::OFS_OPMODE, 8'hff, 8'hc0);
		wr(clksw_pkg::OFS_IOSC, 8'h02);
		check("low speed kept", 32'h1, {31'h0, lowspeed_osc_enable});
		wr(clksw_pkg::OFS_IOSC, 8'h00);
		lowspeed_stop_allowed <= 1'b1;
		wr(clksw_pkg::OFS_IOSC, 8'h02);
		check("low speed halted", 32'h0, {31'h0, lowspeed_osc_enable});
		wr(clksw_pkg::OFS_IOSC, 8'h00);
		check("low speed restart", 32'h1, {31'h0, lowspeed_osc_enable});
		pulse(1);
		check("stop on internal", 32'h2, {30'h0, cpu_stopped, hs_osc_enable});
		pulse(2);
		check("wake from stop", 32'h1, {31'h0, cpu_running});
		wr(clksw_pkg::OFS_MAINMODE, 8'h05);
		poll("cpu on external", clksw_pkg::OFS_MAINMODE, 8'h07, 8'h07);
		wr(clksw_pkg::OFS_OPMODE, 8'hd0);
		wr(clksw_pkg::OFS_PCLK, 8'h10);
		poll("main to sub", clksw_pkg::OFS_PCLK, 8'h30, 8'h30);
		wr(clksw_pkg::OFS_PCLK, 8'h00);
		poll("sub to main", clksw_pkg::OFS_MAINMODE, 8'h07, 8'h07);
		wr(clksw_pkg::OFS_PCLK, 8'h10);
		poll("sub already running", clksw_pkg::OFS_PCLK, 8'h30, 8'h30);
		complete_run();
	end
endmodule // tb_top

`default_nettype wire
